// >>> logic/ssfs_pkg.sv
package ssfs_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CLKDIV = 12'h004;
  localparam logic [11:0] ADDR_DATA = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SLAVE_BIT = 1;
  localparam int CTRL_MW_BIT = 2;
  localparam int CTRL_POL_BIT = 3;
  localparam int CTRL_PHA_BIT = 4;
  localparam int CTRL_DSS_LSB = 8;
  localparam int STAT_TX_EMPTY_BIT = 0;
  localparam int STAT_RX_FULL_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_OVR_BIT = 3;
  localparam logic [3:0] DSS_MIN = 4'h3;
  localparam logic [3:0] DSS_RESET = 4'h7;
  localparam logic [7:0] DIV_RESET = 8'h03;
  localparam logic [5:0] CTRL_BYTE_BITS = 6'h08;
  localparam logic [5:0] MW_HEAD_BITS = 6'h09;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] SYNC_RESET = 3'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LEAD = 3'h1,
    ST_SHIFT = 3'h2,
    ST_TAIL = 3'h3,
    ST_GAP = 3'h4
  } ssfs_state_type;
endpackage

// >>> logic/ssfs_sync_if.sv
interface ssfs_sync_if;
  logic sclk;
  logic fss_n;
  logic rxd;
  logic sclk_rise;
  logic sclk_fall;
  modport producer(output sclk, output fss_n, output rxd, output sclk_rise, output sclk_fall);
  modport consumer(input sclk, input fss_n, input rxd, input sclk_rise, input sclk_fall);
endinterface

// >>> logic/ssfs_pin_sync.sv
module ssfs_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk_pin,
  input wire logic fss_n_pin,
  input wire logic rxd_pin,
  ssfs_sync_if.producer sync
);
  import ssfs_pkg::*;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic sclk_d;
  } ssfs_sync_type;
  ssfs_sync_type r;
  ssfs_sync_type next_r;

  always_comb begin
    next_r = r;
    next_r.s1 = {rxd_pin, fss_n_pin, sclk_pin};
    next_r.s2 = r.s1;
    next_r.sclk_d = r.s2[0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r.s1 <= SYNC_RESET;
      r.s2 <= SYNC_RESET;
      r.sclk_d <= 1'h0;
    end else begin
      r <= next_r;
    end
  end

  assign sync.sclk = r.s2[0];
  assign sync.fss_n = r.s2[1];
  assign sync.rxd = r.s2[2];
  assign sync.sclk_rise = r.s2[0] & ~r.sclk_d;
  assign sync.sclk_fall = ~r.s2[0] & r.sclk_d;
endmodule

// >>> logic/ssfs_sync_serial_unit.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
module ssfs_sync_serial_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ssfs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ssfs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clk_line_pin,
  output logic serial_clk_line,
  output logic serial_clk_line_en_n,
  input wire logic frame_select_line_n_pin,
  output logic frame_select_line_n,
  output logic frame_select_line_en_n,
  output logic tx_data_line,
  output logic tx_data_line_en_n,
  input wire logic rx_data_line_pin
);
  import ssfs_pkg::*;

  typedef struct packed {
    ssfs_state_type st;
    logic [7:0] half_cnt;
    logic [5:0] edge_cnt;
    logic lead_left;
    logic sclk;
    logic fss;
    logic tx_show;
    logic [15:0] tx_sr;
    logic [15:0] rx_sr;
    logic [15:0] tx_hold;
    logic tx_full;
    logic [15:0] rx_hold;
    logic rx_full;
    logic ovr;
    logic en;
    logic slave;
    logic mw;
    logic pol;
    logic pha;
    logic [3:0] dss;
    logic [7:0] div;
    logic [5:0] s_cnt;
    logic s_seen;
    logic s_loaded;
    logic aw_ok;
    logic [ADDR_W-1:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssfs_unit_type;

  ssfs_unit_type r;
  ssfs_unit_type next_r;
  ssfs_sync_if sync();

  ssfs_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .sclk_pin(serial_clk_line_pin),
    .fss_n_pin(frame_select_line_n_pin),
    .rxd_pin(rx_data_line_pin),
    .sync(sync.producer)
  );

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  // left-align the word so its msb leaves first
  function automatic logic [15:0] align_tx(input logic [15:0] v, input logic [3:0] d);
    return 16'(v << (4'hF - d));
  endfunction

  function automatic logic [31:0] ctrl_word(input ssfs_unit_type s);
    logic [31:0] w;
    w = '0;
    w[CTRL_EN_BIT] = s.en;
    w[CTRL_SLAVE_BIT] = s.slave;
    w[CTRL_MW_BIT] = s.mw;
    w[CTRL_POL_BIT] = s.pol;
    w[CTRL_PHA_BIT] = s.pha;
    w[CTRL_DSS_LSB +: 4] = s.dss;
    return w;
  endfunction

  logic busy;
  assign busy = (r.st != ST_IDLE) || (r.slave && !sync.fss_n);

  always_comb begin
    logic tick;
    logic [4:0] dsz;
    logic [5:0] nbits;
    logic cap_odd;
    logic more;
    logic do_edge;
    logic start_word;
    logic push;
    logic [15:0] push_mask;
    logic [5:0] k;
    logic is_cap;
    logic last;
    logic s_cap;
    logic s_chg;
    logic [31:0] m;
    logic [31:0] cw;
    logic [31:0] sw;
    tick = (r.half_cnt == 8'h00);
    dsz = {1'h0, r.dss} + 5'h01;
    nbits = r.mw ? (6'(dsz) + MW_HEAD_BITS) : 6'(dsz);
    cap_odd = r.mw || !r.pha;
    more = r.en && !r.slave && r.tx_full;
    do_edge = 1'h0;
    start_word = 1'h0;
    push = 1'h0;
    push_mask = 16'((17'h00001 << dsz) - 17'h00001);
    k = r.edge_cnt + 6'h01;
    is_cap = cap_odd ? k[0] : !k[0];
    last = (k == {nbits[4:0], 1'h0});
    s_cap = (r.mw || (r.pol == r.pha)) ? sync.sclk_rise : sync.sclk_fall;
    s_chg = (r.mw || (r.pol == r.pha)) ? sync.sclk_fall : sync.sclk_rise;
    m = strb_mask(r.wstrb);
    cw = (ctrl_word(r) & ~m) | (r.wdata & m);
    sw = '0;
    sw[STAT_TX_EMPTY_BIT] = !r.tx_full;
    sw[STAT_RX_FULL_BIT] = r.rx_full;
    sw[STAT_BUSY_BIT] = busy;
    sw[STAT_OVR_BIT] = r.ovr;
    next_r = r;

    // register bus
    if (s_axi_awvalid && !r.aw_ok && !r.bvalid) begin
      next_r.aw_ok = 1'h1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_ok && !r.bvalid) begin
      next_r.w_ok = 1'h1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.aw_ok && r.w_ok) begin
      next_r.aw_ok = 1'h0;
      next_r.w_ok = 1'h0;
      next_r.bvalid = 1'h1;
      next_r.bresp = RESP_OKAY;
      case (r.awaddr)
        ADDR_CTRL: begin
          next_r.en = cw[CTRL_EN_BIT];
          next_r.slave = cw[CTRL_SLAVE_BIT];
          next_r.mw = cw[CTRL_MW_BIT];
          next_r.pol = cw[CTRL_POL_BIT];
          next_r.pha = cw[CTRL_PHA_BIT];
          next_r.dss = (cw[CTRL_DSS_LSB +: 4] < DSS_MIN) ? DSS_MIN : cw[CTRL_DSS_LSB +: 4];
        end
        ADDR_CLKDIV: begin
          if (r.wstrb[0]) begin
            next_r.div = r.wdata[7:0];
          end
        end
        ADDR_DATA: begin
          if ((r.wstrb[0] || r.wstrb[1]) && !r.tx_full) begin
            next_r.tx_hold = r.wdata[15:0];
            next_r.tx_full = 1'h1;
          end
        end
        ADDR_STATUS: begin
          if (r.wstrb[0] && r.wdata[STAT_OVR_BIT]) begin
            next_r.ovr = 1'h0;
          end
        end
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'h0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'h1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = '0;
      case (s_axi_araddr)
        ADDR_CTRL: next_r.rdata = ctrl_word(r);
        ADDR_CLKDIV: next_r.rdata = {24'h000000, r.div};
        ADDR_DATA: begin
          next_r.rdata = {16'h0000, r.rx_hold};
          next_r.rx_full = 1'h0;
        end
        ADDR_STATUS: next_r.rdata = sw;
        default: next_r.rresp = RESP_SLVERR;
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'h0;
    end

    // master sequencer
    next_r.half_cnt = tick ? r.div : r.half_cnt - 8'h01;
    case (r.st)
      ST_IDLE: begin
        next_r.half_cnt = r.div;
        next_r.sclk = !r.mw && r.pol;
        next_r.fss = 1'h1;
        next_r.tx_show = 1'h0;
        if (more) begin
          start_word = 1'h1;
          next_r.st = ST_LEAD;
          next_r.fss = 1'h0;
          next_r.lead_left = !r.mw && !r.pha;
          next_r.tx_show = r.mw;
        end
      end
      ST_LEAD: begin
        if (tick) begin
          if (r.lead_left) begin
            next_r.lead_left = 1'h0;
            next_r.tx_show = 1'h1;
          end else begin
            do_edge = 1'h1;
            next_r.st = ST_SHIFT;
          end
        end
      end
      ST_SHIFT: begin
        do_edge = tick;
      end
      ST_TAIL: begin
        if (tick) begin
          if (r.lead_left) begin
            next_r.lead_left = 1'h0;
          end else if (more && r.pha && !r.mw) begin
            start_word = 1'h1;
            next_r.st = ST_LEAD;
            next_r.tx_show = 1'h0;
          end else begin
            next_r.fss = 1'h1;
            next_r.tx_show = 1'h0;
            push = r.mw;
            next_r.st = more ? ST_GAP : ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        if (tick) begin
          start_word = 1'h1;
          next_r.st = ST_LEAD;
          next_r.fss = 1'h0;
          next_r.lead_left = !r.mw && !r.pha;
          next_r.tx_show = r.mw;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    // one serial clock edge: capture or change
    if (do_edge) begin
      next_r.edge_cnt = k;
      next_r.sclk = !r.sclk;
      if (is_cap) begin
        if (!r.mw || ({1'h0, r.edge_cnt[5:1]} >= MW_HEAD_BITS)) begin
          next_r.rx_sr = {r.rx_sr[14:0], sync.rxd};
        end
      end else if (k == 6'h01) begin
        next_r.tx_show = 1'h1;
      end else if (!last) begin
        next_r.tx_sr = {r.tx_sr[14:0], 1'h0};
      end
      if (last) begin
        next_r.edge_cnt = 6'h00;
        push = !r.mw || more;
        if (r.mw && more) begin
          start_word = 1'h1;
          next_r.st = ST_LEAD;
          next_r.lead_left = 1'h0;
          next_r.tx_show = 1'h1;
        end else begin
          next_r.st = ST_TAIL;
          next_r.lead_left = !cap_odd;
        end
      end
    end
    if (start_word) begin
      next_r.tx_sr = r.mw ? {r.tx_hold[7:0], 8'h00} : align_tx(r.tx_hold, r.dss);
      next_r.tx_full = 1'h0;
      next_r.edge_cnt = 6'h00;
      next_r.half_cnt = r.div;
    end

    // slave path, driven by the external clock
    if (r.en && r.slave && r.st == ST_IDLE) begin
      if (sync.fss_n) begin
        next_r.s_cnt = 6'h00;
        next_r.s_seen = 1'h0;
        next_r.tx_show = 1'h0;
        if (r.tx_full && !r.s_loaded) begin
          next_r.tx_sr = align_tx(r.tx_hold, r.dss);
          next_r.tx_full = 1'h0;
          next_r.s_loaded = 1'h1;
        end
      end else begin
        next_r.tx_show = !r.mw || r.tx_show;
        if (s_cap) begin
          next_r.s_seen = 1'h1;
          next_r.s_cnt = r.s_cnt + 6'h01;
          if (!r.mw || r.s_cnt < CTRL_BYTE_BITS) begin
            next_r.rx_sr = {r.rx_sr[14:0], sync.rxd};
          end
          if (r.mw && next_r.s_cnt == CTRL_BYTE_BITS) begin
            push = 1'h1;
            push_mask = 16'h00FF;
          end
          if (next_r.s_cnt == nbits) begin
            push = !r.mw;
            next_r.s_cnt = 6'h00;
            next_r.s_seen = 1'h0;
            next_r.tx_show = !r.mw;
            next_r.s_loaded = r.tx_full;
            next_r.tx_sr = r.tx_full ? align_tx(r.tx_hold, r.dss) : 16'h0000;
            next_r.tx_full = 1'h0;
          end
        end
        if (s_chg) begin
          if (r.mw) begin
            if (r.s_cnt == MW_HEAD_BITS) begin
              next_r.tx_show = 1'h1;
            end else if (r.s_cnt > MW_HEAD_BITS) begin
              next_r.tx_sr = {r.tx_sr[14:0], 1'h0};
            end
          end else if (r.s_seen) begin
            next_r.tx_sr = {r.tx_sr[14:0], 1'h0};
          end
        end
      end
    end else begin
      next_r.s_cnt = 6'h00;
      next_r.s_seen = 1'h0;
      next_r.s_loaded = 1'h0;
    end

    // received word into the holding register; a new word beats a read
    if (push) begin
      if (next_r.rx_full) begin
        next_r.ovr = 1'h1;
      end
      next_r.rx_hold = next_r.rx_sr & push_mask;
      next_r.rx_full = 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.fss <= 1'h1;
      r.div <= DIV_RESET;
      r.dss <= DSS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = !r.aw_ok && !r.bvalid;
  assign s_axi_wready = !r.w_ok && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  // pad drive: master owns clock and select, slave releases them
  assign serial_clk_line = r.sclk;
  assign serial_clk_line_en_n = r.slave;
  assign frame_select_line_n = r.fss;
  assign frame_select_line_en_n = r.slave;
  assign tx_data_line = r.tx_show & r.tx_sr[15];
  assign tx_data_line_en_n = r.slave & sync.fss_n;
endmodule

// >>> verif/ssfs_properties.sv
module ssfs_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clk_line,
  input wire logic serial_clk_line_en_n,
  input wire logic frame_select_line_n,
  input wire logic frame_select_line_en_n,
  input wire logic tx_data_line_en_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_answer;
    !s_axi_awready ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_both_taken |=> s_answer)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped before taken");
  a_pads_paired: assert property (serial_clk_line_en_n == frame_select_line_en_n)
    else $error("clock and select pads disagree");
  a_tx_enabled: assert property (
    !frame_select_line_en_n && !frame_select_line_n |-> !tx_data_line_en_n)
    else $error("tx pad off in frame");
  a_clock_idle: assert property (
    frame_select_line_n && $past(frame_select_line_n) && !frame_select_line_en_n && !s_axi_bvalid
    && !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2) |-> $stable(serial_clk_line))
    else $error("clock moved outside frame");
  a_start_settled: assert property (
    $fell(frame_select_line_n) && !frame_select_line_en_n |-> $stable(serial_clk_line))
    else $error("clock edge with select fall");
  a_end_settled: assert property (
    $rose(frame_select_line_n) && !frame_select_line_en_n |-> $stable(serial_clk_line)[*2])
    else $error("clock moved at frame end");
endmodule
bind ssfs_sync_serial_unit ssfs_properties u_ssfs_properties (.*);

// >>> verif/ssfs_far_slave.sv
module ssfs_far_slave (
  input wire logic serial_clk_line,
  input wire logic frame_select_line_n,
  input wire logic tx_data_line,
  input wire logic clock_idle_polarity,
  input wire logic clock_phase_select,
  input wire logic resp_format,
  input wire logic [4:0] size,
  input wire logic [15:0] reply,
  output logic reply_bit,
  output logic [15:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  int p, rises;
  initial reply_bit = 1'b0;
  always @(negedge frame_select_line_n) begin
    p = size - 1;
    rises = 0;
    got = '0;
    if (!resp_format && !clock_phase_select) reply_bit = reply[p];
  end
  always @(posedge frame_select_line_n) reply_bit = ~reply_bit;
  always @(serial_clk_line) begin
    if (!frame_select_line_n && serial_clk_line == (resp_format
        || clock_idle_polarity == clock_phase_select)) begin
      if (!resp_format || rises < 8) got = {got[14:0], tx_data_line};
      rises++;
    end else if (!frame_select_line_n && resp_format) begin
      if (rises >= 9 && p >= 0) begin
        reply_bit = reply[p];
        p--;
      end
    end else if (!frame_select_line_n) begin
      if (!clock_phase_select) p--;
      if (p >= 0) reply_bit = reply[p];
      if (clock_phase_select) p--;
    end
  end
endmodule

// >>> verif/test_sync_serial_frame_sequencer.sv
module test_sync_serial_frame_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import ssfs_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic serial_clk_line, serial_clk_line_en_n, frame_select_line_n, frame_select_line_en_n;
  logic tx_data_line, tx_data_line_en_n, serial_clk_line_pin, frame_select_line_n_pin;
  logic rx_data_line_pin, link_clk, link_fss, link_rx, slave_on, reply_bit, pol, pha, mw;
  logic [4:0] size;
  logic [15:0] reply, got;
  int bad_count, num_checks, cycles, rises;
  realtime t_fall, t_edge, lead, gap;
  bit lead_open;
  localparam int HALF_NS = 24;
  assign serial_clk_line_pin = serial_clk_line_en_n ? link_clk : serial_clk_line;
  assign frame_select_line_n_pin = frame_select_line_en_n ? link_fss : frame_select_line_n;
  assign rx_data_line_pin = slave_on ? link_rx : reply_bit;
  ssfs_sync_serial_unit u_ssfs_sync_serial_unit (.*);
  ssfs_far_slave u_ssfs_far_slave (.*, .clock_idle_polarity(pol), .clock_phase_select(pha),
    .resp_format(mw));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  always @(posedge frame_select_line_n) begin
    rises++;
    gap = $realtime - t_edge;
  end
  always @(negedge frame_select_line_n) begin
    t_fall = $realtime;
    lead_open = 1'b1;
  end
  always @(serial_clk_line) begin
    t_edge = $realtime;
    if (lead_open) lead = $realtime - t_fall;
    lead_open = 1'b0;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    bit aw, w, b;
    {aw, w, b} = 3'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b) begin
      @(negedge aclk);
      aw = aw | (s_axi_awvalid & s_axi_awready);
      w = w | (s_axi_wvalid & s_axi_wready);
      b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [ADDR_W-1:0] a);
    bit ar, rv;
    rv = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!rv) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_idle();
    do axi_read(ADDR_STATUS); while (d[STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic frame_test(input logic [7:0] ctl, input logic [4:0] n,
      input logic [15:0] tx, input logic [15:0] rep);
    logic [15:0] mask;
    mask = 16'hFFFF >> (5'h10 - n);
    {pha, pol, mw} = ctl[4:2];
    size = n;
    reply = rep;
    axi_write(ADDR_CTRL, {20'h00000, 4'(n - 5'h01), ctl});
    axi_read(ADDR_STATUS);
    check("clock idle", pol & ~mw, serial_clk_line);
    check("select idle", 1, frame_select_line_n);
    check("tx idle", 0, tx_data_line);
    axi_write(ADDR_DATA, {16'h0000, tx});
    wait_idle();
    check("rx stored", 1, d[STAT_RX_FULL_BIT]);
    check("select after", 1, frame_select_line_n);
    check("clock lead", (pha | mw) ? HALF_NS : 2 * HALF_NS, int'(lead));
    check("select gap", pha ? 2 * HALF_NS : HALF_NS, int'(gap));
    check("far word", mw ? tx[7:0] : tx & mask, got);
    axi_read(ADDR_DATA);
    check("rx word", rep & mask, d);
  endtask
  task automatic run_test(input logic [7:0] ctl, input int exp);
    axi_write(ADDR_CTRL, {24'h000007, ctl});
    rises = 0;
    axi_write(ADDR_DATA, 32'h00000081);
    do axi_read(ADDR_STATUS); while (d[STAT_TX_EMPTY_BIT] !== 1'b1);
    axi_write(ADDR_DATA, 32'h00000042);
    wait_idle();
    check("select rises", exp, rises);
  endtask
  task automatic slave_test(input logic [31:0] ctl, input logic idle);
    axi_read(ADDR_DATA);
    {slave_on, link_clk} <= {1'b1, idle};
    axi_write(ADDR_CTRL, ctl);
    axi_read(ADDR_STATUS);
    check("clock pad released", 1, serial_clk_line_en_n);
    link_fss <= 1'b0;
    repeat (10) @(posedge aclk);
    for (int i = 7; i >= 0; i--) begin
      link_clk <= 1'b0;
      link_rx <= 1'(8'h96 >> i);
      repeat (5) @(posedge aclk);
      link_clk <= 1'b1;
      repeat (5) @(posedge aclk);
    end
    link_fss <= 1'b1;
    link_rx <= ~link_rx;
    do axi_read(ADDR_STATUS); while (d[STAT_RX_FULL_BIT] !== 1'b1);
    axi_read(ADDR_DATA);
    check("slave rx word", 32'h00000096, d);
    link_clk <= idle;
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {link_clk, link_rx, slave_on, pol, pha, mw} = 6'h00;
    {link_fss, s_axi_wstrb} = 5'h1F;
    size = 5'h08;
    reply = 16'h0000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ADDR_CTRL);
    check("ctrl reset", 32'h00000700, d);
    axi_read(ADDR_CLKDIV);
    check("divider reset", DIV_RESET, d);
    axi_read(12'h010);
    check("unmapped resp", RESP_SLVERR, r);
    axi_write(ADDR_CLKDIV, 32'h00000002);
    axi_read(ADDR_CLKDIV);
    check("divider set", 32'h00000002, d);
    frame_test(8'h11, 5'h08, 16'h00A5, 16'h003C);
    frame_test(8'h09, 5'h10, 16'hC33C, 16'h8E71);
    frame_test(8'h19, 5'h04, 16'h0009, 16'h0006);
    frame_test(8'h05, 5'h10, 16'h005A, 16'hB2D4);
    run_test(8'h09, 2);
    run_test(8'h19, 1);
    run_test(8'h05, 1);
    slave_test(32'h0000071B, 1'b1);
    slave_test(32'h00000707, 1'b0);
    tally_and_finish();
  end
endmodule
